// File: include/acpd_pkg.sv
// Package with port offsets, field layouts and reset values for the card port decoder.
package acpd_pkg;

	localparam int ACPD_ADDR_W = 4;
	localparam logic [3:0] ACPD_OFS_CNT0 = 4'h0;
	localparam logic [3:0] ACPD_OFS_CNT1 = 4'h1;
	localparam logic [3:0] ACPD_OFS_CNT2 = 4'h2;
	localparam logic [3:0] ACPD_OFS_CNT_CTRL = 4'h3;
	localparam logic [3:0] ACPD_OFS_CONV_LO = 4'h4;
	localparam logic [3:0] ACPD_OFS_CONV_HI = 4'h5;
	localparam logic [3:0] ACPD_OFS_DIN_LO = 4'h6;
	localparam logic [3:0] ACPD_OFS_DIN_HI = 4'h7;
	localparam logic [3:0] ACPD_OFS_IRQ_CLR = 4'h8;
	localparam logic [3:0] ACPD_OFS_GAIN = 4'h9;
	localparam logic [3:0] ACPD_OFS_CHAN = 4'ha;
	localparam logic [3:0] ACPD_OFS_MODE = 4'hb;
	localparam logic [3:0] ACPD_OFS_TRIG = 4'hc;
	localparam logic [3:0] ACPD_OFS_DOUT_LO = 4'hd;
	localparam logic [3:0] ACPD_OFS_DOUT_HI = 4'he;

	localparam int ACPD_SEL_W = 3;
	localparam int ACPD_RES_W = 12;
	localparam int ACPD_FLAG_POS = 4;
	localparam logic [2:0] ACPD_CHAN_RST = 3'h0;
	localparam logic [2:0] ACPD_GAIN_RST = 3'h0;
	localparam logic [7:0] ACPD_BYTE_RST = 8'h00;
	localparam logic ACPD_FLAG_RST = 1'b1;

	// One host I/O cycle, already qualified by the base-address match.
	typedef struct packed {
		logic sel;
		logic rd;
		logic wr;
		logic [3:0] addr;
		logic [7:0] wdata;
	} acpd_io_t;

	// Strobes toward the counter chip.
	typedef struct packed {
		logic rd;
		logic wr;
		logic [1:0] addr;
		logic [7:0] wdata;
	} acpd_cnt_t;

endpackage

// File: rtl/acpd_port_decoder.sv
// Sixteen-port host I/O decoder for the data acquisition card.
`timescale 1ns/1ps
//
// Overview of operation
// R1 - Sixteen byte ports, low four address bits.
// R2 - Ports 0-2 counters; port 3 control word.
// R3 - Port 4/5 read result, write converter output.
// R4 - Ports 6/7 read digital inputs only.
// R5 - Write port 8 clears interrupt request.
// R6 - Ports 9/10/11 load gain, channel, mode.
// R7 - Write port 12 issues software trigger.
// R8 - Ports 13/14 digital output; 15 unused.
// R9 - Result split low eight, high four bits.
// R10 - High byte bits 7-5 zero, bit4 flag.
// R11 - Flag 0 when done, 1 not ready.
// R12 - Reading result low byte sets flag.
// R13 - Channel takes bits 2-0, binary number.
// R14 - Channel write routes multiplexer immediately.
// R15 - Gain takes bits 2-0, codes 0-4.
// R16 - Host never writes gain codes 5-7.
// R17 - Eight single-ended input channels.
// R18 - Host clears interrupt after each conversion.
// R19 - Any trigger write starts one conversion.
// R20 - Reset selects channel 0, gain x1.
module acpd_port_decoder (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire acpd_pkg::acpd_io_t i_io,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	output acpd_pkg::acpd_cnt_t o_cnt,
	input wire logic [7:0] i_cnt_rdata,
	input wire logic [11:0] i_conv_result,
	input wire logic i_conv_done,
	input wire logic [15:0] i_digital_in_bits,
	output logic [15:0] o_digital_out,
	output logic [11:0] o_dac_value,
	output logic o_dac_update,
	output logic [2:0] o_channel_select,
	output logic [2:0] o_gain_code,
	output logic [7:0] o_mode,
	output logic o_irq_clear,
	output logic o_soft_trigger
);
	import acpd_pkg::*;

	// ==========================================================
	// Decode
	function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
		hit = (a == ofs);
	endfunction

	logic rd_c;
	logic wr_c;
	logic [3:0] a_c;
	assign rd_c = i_io.sel && i_io.rd;
	assign wr_c = i_io.sel && i_io.wr;
	assign a_c = i_io.addr[ACPD_ADDR_W-1:0]; // R1

	// Counter pass-through; port 3 is write-only, so reads there are not forwarded.
	always_comb begin
		o_cnt.rd = rd_c && (a_c < ACPD_OFS_CNT_CTRL); // R2
		o_cnt.wr = wr_c && (a_c <= ACPD_OFS_CNT_CTRL); // R2
		o_cnt.addr = a_c[1:0];
		o_cnt.wdata = i_io.wdata;
	end

	// ==========================================================
	// State
	logic [7:0] rdata_ff, nxt_rdata;
	logic rvalid_ff, nxt_rvalid;
	logic [7:0] dout_lo_ff, nxt_dout_lo;
	logic [7:0] dout_hi_ff, nxt_dout_hi;
	logic [7:0] dac_lo_ff, nxt_dac_lo;
	logic [11:0] dac_ff, nxt_dac;
	logic dac_upd_ff, nxt_dac_upd;
	logic [2:0] chan_ff, nxt_chan;
	logic [2:0] gain_ff, nxt_gain;
	logic [7:0] mode_ff, nxt_mode;
	logic irq_clr_ff, nxt_irq_clr;
	logic trig_ff, nxt_trig;
	logic [11:0] result_ff, nxt_result;
	logic flag_ff, nxt_flag;

	always_comb begin
		nxt_rdata = ACPD_BYTE_RST;
		nxt_rvalid = rd_c;
		nxt_dout_lo = dout_lo_ff;
		nxt_dout_hi = dout_hi_ff;
		nxt_dac_lo = dac_lo_ff;
		nxt_dac = dac_ff;
		nxt_dac_upd = 1'b0;
		nxt_chan = chan_ff;
		nxt_gain = gain_ff;
		nxt_mode = mode_ff;
		nxt_irq_clr = 1'b0;
		nxt_trig = 1'b0;
		nxt_result = result_ff;
		nxt_flag = flag_ff;
		// Reading the low byte marks the data stale; a completion in the same cycle wins.
		if (rd_c && hit(a_c, ACPD_OFS_CONV_LO)) begin
			nxt_flag = 1'b1; // R12
		end
		if (i_conv_done) begin
			nxt_result = i_conv_result;
			nxt_flag = 1'b0; // R11
		end
		// A new trigger marks the result not ready while converting.
		if (wr_c && hit(a_c, ACPD_OFS_TRIG) && !i_conv_done) begin
			nxt_flag = 1'b1; // R11
		end
		if (rd_c) begin
			case (a_c)
				ACPD_OFS_CNT0, ACPD_OFS_CNT1, ACPD_OFS_CNT2: begin
					nxt_rdata = i_cnt_rdata; // R2
				end
				ACPD_OFS_CONV_LO: begin
					nxt_rdata = result_ff[7:0]; // R3 R9
				end
				ACPD_OFS_CONV_HI: begin
					nxt_rdata = {3'h0, flag_ff, result_ff[ACPD_RES_W-1:8]}; // R9 R10
				end
				ACPD_OFS_DIN_LO: begin
					nxt_rdata = i_digital_in_bits[7:0]; // R4
				end
				ACPD_OFS_DIN_HI: begin
					nxt_rdata = i_digital_in_bits[15:8]; // R4
				end
				default: begin
					nxt_rdata = ACPD_BYTE_RST; // R8
				end
			endcase
		end
		if (wr_c) begin
			case (a_c)
				ACPD_OFS_CONV_LO: begin
					nxt_dac_lo = i_io.wdata; // R3
				end
				ACPD_OFS_CONV_HI: begin
					// Output changes only when the high byte lands.
					nxt_dac = {i_io.wdata[3:0], dac_lo_ff}; // R3
					nxt_dac_upd = 1'b1;
				end
				ACPD_OFS_IRQ_CLR: begin
					nxt_irq_clr = 1'b1; // R5 R18
				end
				ACPD_OFS_GAIN: begin
					nxt_gain = i_io.wdata[ACPD_SEL_W-1:0]; // R6 R15 R16
				end
				ACPD_OFS_CHAN: begin
					nxt_chan = i_io.wdata[ACPD_SEL_W-1:0]; // R6 R13 R14 R17
				end
				ACPD_OFS_MODE: begin
					nxt_mode = i_io.wdata; // R6
				end
				ACPD_OFS_TRIG: begin
					nxt_trig = 1'b1; // R7 R19
				end
				ACPD_OFS_DOUT_LO: begin
					nxt_dout_lo = i_io.wdata; // R8
				end
				ACPD_OFS_DOUT_HI: begin
					nxt_dout_hi = i_io.wdata; // R8
				end
				default: begin
					nxt_mode = mode_ff; // R4 R8
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			rdata_ff <= ACPD_BYTE_RST;
			rvalid_ff <= 1'b0;
			dout_lo_ff <= ACPD_BYTE_RST;
			dout_hi_ff <= ACPD_BYTE_RST;
			dac_lo_ff <= ACPD_BYTE_RST;
			dac_ff <= 12'h000;
			dac_upd_ff <= 1'b0;
			chan_ff <= ACPD_CHAN_RST; // R20
			gain_ff <= ACPD_GAIN_RST; // R20
			mode_ff <= ACPD_BYTE_RST;
			irq_clr_ff <= 1'b0;
			trig_ff <= 1'b0;
			result_ff <= 12'h000;
			flag_ff <= ACPD_FLAG_RST;
		end else begin
			rdata_ff <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
			dout_lo_ff <= nxt_dout_lo;
			dout_hi_ff <= nxt_dout_hi;
			dac_lo_ff <= nxt_dac_lo;
			dac_ff <= nxt_dac;
			dac_upd_ff <= nxt_dac_upd;
			chan_ff <= nxt_chan;
			gain_ff <= nxt_gain;
			mode_ff <= nxt_mode;
			irq_clr_ff <= nxt_irq_clr;
			trig_ff <= nxt_trig;
			result_ff <= nxt_result;
			flag_ff <= nxt_flag;
		end
	end

	assign o_rdata = rdata_ff;
	assign o_rvalid = rvalid_ff;
	assign o_digital_out = {dout_hi_ff, dout_lo_ff};
	assign o_dac_value = dac_ff;
	assign o_dac_update = dac_upd_ff;
	assign o_channel_select = chan_ff;
	assign o_gain_code = gain_ff;
	assign o_mode = mode_ff;
	assign o_irq_clear = irq_clr_ff;
	assign o_soft_trigger = trig_ff;

	// ==========================================================
	// Checks
	chan_load_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R13
		wr_c && a_c == ACPD_OFS_CHAN |=> o_channel_select == $past(i_io.wdata[2:0]))
		else $error("channel latch did not load");
	gain_load_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R15
		wr_c && a_c == ACPD_OFS_GAIN |=> o_gain_code == $past(i_io.wdata[2:0]))
		else $error("gain latch did not load");
	chan_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R14
		!(wr_c && a_c == ACPD_OFS_CHAN) |=> $stable(o_channel_select))
		else $error("channel changed without write");
	trig_pulse_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R19
		wr_c && a_c == ACPD_OFS_TRIG |=> o_soft_trigger ##1 (!o_soft_trigger || $past(nxt_trig)))
		else $error("trigger not a single pulse");
	trig_only_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R7
		o_soft_trigger |-> $past(wr_c) && $past(a_c) == ACPD_OFS_TRIG)
		else $error("spurious trigger");
	irq_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R5
		o_irq_clear == ($past(wr_c) && $past(a_c) == ACPD_OFS_IRQ_CLR))
		else $error("interrupt clear mismatch");
	hi_byte_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R10
		rd_c && a_c == ACPD_OFS_CONV_HI |=> o_rdata[7:5] == 3'h0 && o_rdata[4] == $past(flag_ff))
		else $error("high byte format wrong");
	flag_done_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R11
		i_conv_done |=> !flag_ff && result_ff == $past(i_conv_result))
		else $error("done not captured");
	flag_set_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R12
		rd_c && a_c == ACPD_OFS_CONV_LO && !i_conv_done |=> flag_ff)
		else $error("low read did not set flag");
	din_read_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R4
		rd_c && a_c == ACPD_OFS_DIN_HI |=> o_rdata == $past(i_digital_in_bits[15:8]))
		else $error("digital in high wrong");
	dac_double_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R3
		wr_c && a_c == ACPD_OFS_CONV_LO |=> $stable(o_dac_value))
		else $error("converter output changed on low byte");
	unused_rd_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R8
		rd_c && a_c == 4'hf |=> o_rdata == 8'h00)
		else $error("unused port read nonzero");
	// Every read is answered once, and an idle cycle leaves the read byte at zero.
	read_answer_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R1
		rd_c |=> o_rvalid)
		else $error("read not answered");
	read_idle_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R1
		!rd_c |=> !o_rvalid && o_rdata == ACPD_BYTE_RST)
		else $error("read data without read");
	cnt_read_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R2
		rd_c && a_c < ACPD_OFS_CNT_CTRL |-> o_cnt.rd && o_cnt.addr == a_c[1:0])
		else $error("counter read not forwarded");
	cnt_ctrl_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R2
		rd_c && a_c >= ACPD_OFS_CNT_CTRL |-> !o_cnt.rd)
		else $error("counter read outside counters");
	cnt_write_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R2
		wr_c && a_c <= ACPD_OFS_CNT_CTRL |-> o_cnt.wr && o_cnt.wdata == i_io.wdata)
		else $error("counter write not forwarded");
	cnt_data_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R2
		rd_c && a_c < ACPD_OFS_CNT_CTRL |=> o_rdata == $past(i_cnt_rdata))
		else $error("counter read data wrong");
	lo_byte_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R9
		rd_c && a_c == ACPD_OFS_CONV_LO |=> o_rdata == $past(result_ff[7:0]))
		else $error("result low byte wrong");
	hi_nibble_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R9
		rd_c && a_c == ACPD_OFS_CONV_HI |=> o_rdata[3:0] == $past(result_ff[11:8]))
		else $error("result high bits wrong");
	din_low_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R4
		rd_c && a_c == ACPD_OFS_DIN_LO |=> o_rdata == $past(i_digital_in_bits[7:0]))
		else $error("digital in low wrong");
	din_nowrite_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R4
		wr_c && (a_c == ACPD_OFS_DIN_LO || a_c == ACPD_OFS_DIN_HI) |=> $stable(o_digital_out))
		else $error("digital in write had effect");
	unused_wr_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R8
		wr_c && a_c == 4'hf |=> $stable(o_digital_out) && !o_irq_clear && !o_soft_trigger)
		else $error("unused port write had effect");
	dout_low_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R8
		wr_c && a_c == ACPD_OFS_DOUT_LO |=> o_digital_out[7:0] == $past(i_io.wdata))
		else $error("digital out low not loaded");
	dout_high_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R8
		wr_c && a_c == ACPD_OFS_DOUT_HI |=> o_digital_out[15:8] == $past(i_io.wdata))
		else $error("digital out high not loaded");
	mode_load_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R6
		wr_c && a_c == ACPD_OFS_MODE |=> o_mode == $past(i_io.wdata))
		else $error("mode latch did not load");
	dac_load_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R3
		wr_c && a_c == ACPD_OFS_CONV_HI |=> o_dac_update && o_dac_value == $past({i_io.wdata[3:0], dac_lo_ff}))
		else $error("converter output not loaded");
	dac_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R3
		!(wr_c && a_c == ACPD_OFS_CONV_HI) |=> !o_dac_update && $stable(o_dac_value))
		else $error("converter output changed without high byte");
	gain_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R15
		!(wr_c && a_c == ACPD_OFS_GAIN) |=> $stable(o_gain_code))
		else $error("gain changed without write");
	flag_trig_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R11
		wr_c && a_c == ACPD_OFS_TRIG && !i_conv_done |=> flag_ff)
		else $error("trigger did not mark result stale");
	reset_sel_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R20
		$past(i_rst) |-> o_channel_select == ACPD_CHAN_RST && o_gain_code == ACPD_GAIN_RST)
		else $error("latches not at reset selection");

endmodule // acpd_port_decoder

// File: verification/acpd_conv_model.sv
// Converter and counter chip model beside the card port decoder.
`timescale 1ns/1ps
module acpd_conv_model (
	input wire logic i_ref_clk,
	input wire logic i_start,
	input wire acpd_pkg::acpd_cnt_t i_cnt,
	output logic o_done,
	output logic [11:0] o_result,
	output logic [7:0] o_cnt_rdata
);
	import acpd_pkg::*;
	int cnt = -1;
	logic done_q = 1'b0;
	assign o_done = done_q;
	// Counter data is only valid while read; otherwise the bus shows a pattern taken from the conversion countdown.
	assign o_cnt_rdata = i_cnt.rd ? {6'h14, i_cnt.addr} : (8'hc3 ^ cnt[7:0]);
	assign o_result = (cnt <= 0) ? 12'habc : 12'h543;
	always @(posedge i_ref_clk) begin
		done_q <= (cnt == 1);
		if (i_start)
			cnt <= 5;
		else if (cnt >= 0)
			cnt <= cnt - 1;
	end
endmodule // acpd_conv_model

// File: verification/acpd_port_decoder_tb.sv
// Self-checking bench for the card port decoder.
`timescale 1ns/1ps
module acpd_port_decoder_tb;
	import acpd_pkg::*;
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	acpd_io_t io = '0;
	acpd_cnt_t cnt;
	logic [7:0] rdata, cnt_rdata, mode;
	logic rvalid, done, dac_upd, irq_clr, trig;
	logic [11:0] result, dac;
	logic [15:0] din = 16'h5a3c;
	logic [15:0] dout;
	logic [2:0] chan, gain;
	int fails = 0;
	int checked = 0;
	always #10 i_ref_clk = ~i_ref_clk;
	acpd_port_decoder acpd_port_decoder_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_io(io), .o_rdata(rdata),
		.o_rvalid(rvalid), .o_cnt(cnt), .i_cnt_rdata(cnt_rdata), .i_conv_result(result), .i_conv_done(done),
		.i_digital_in_bits(din), .o_digital_out(dout), .o_dac_value(dac), .o_dac_update(dac_upd),
		.o_channel_select(chan), .o_gain_code(gain), .o_mode(mode), .o_irq_clear(irq_clr), .o_soft_trigger(trig));
	acpd_conv_model acpd_conv_model_i (.i_ref_clk(i_ref_clk), .i_start(trig), .i_cnt(cnt), .o_done(done),
		.o_result(result), .o_cnt_rdata(cnt_rdata));
	// ==========
	// Tasks
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic put(input logic [3:0] a, input logic [7:0] d);
		@(negedge i_ref_clk);
		io = '{sel: 1'b1, rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(negedge i_ref_clk);
		io = '0;
	endtask
	task automatic get(input logic [3:0] a, input logic [7:0] exp);
		@(negedge i_ref_clk);
		io = '{sel: 1'b1, rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(negedge i_ref_clk);
		io = '0;
		chk("rvalid", {15'h0, rvalid}, 16'h1);
		chk("rdata", {8'h0, rdata}, {8'h0, exp});
	endtask
	task automatic t_counters();
		for (int k = 0; k < 3; k++) begin
			get(k[3:0], {6'h14, k[1:0]});
		end
		for (int k = 0; k < 4; k++) begin
			@(negedge i_ref_clk);
			io = '{sel: 1'b1, rd: 1'b0, wr: 1'b1, addr: k[3:0], wdata: {4'h3, k[3:0]}};
			#1 chk("cnt", {cnt.wr, cnt.rd, cnt.addr, 4'h0, cnt.wdata}, {2'b10, k[1:0], 8'h03, k[3:0]});
		end
		@(negedge i_ref_clk);
		io = '0;
		get(ACPD_OFS_CNT_CTRL, 8'h00);
	endtask
	task automatic t_latches();
		put(ACPD_OFS_CHAN, 8'hfd);
		chk("chan", {13'h0, chan}, 16'h5);
		for (int g = 0; g < 5; g++) begin
			put(ACPD_OFS_GAIN, {5'h1f, g[2:0]});
			chk("gain", {13'h0, gain}, g[15:0]);
		end
		put(ACPD_OFS_MODE, 8'ha6);
		chk("mode", {8'h0, mode}, 16'h00a6);
		for (int k = 8; k < 16; k++) begin
			get(k[3:0], 8'h00);
		end
		put(ACPD_OFS_DIN_LO, 8'hff);
		put(ACPD_OFS_DIN_HI, 8'hff);
		put(4'hf, 8'hff);
		chk("dout", dout, 16'h0);
		put(ACPD_OFS_DOUT_LO, 8'h81);
		put(ACPD_OFS_DOUT_HI, 8'h7e);
		chk("dout", dout, 16'h7e81);
		get(ACPD_OFS_DIN_LO, 8'h3c);
		get(ACPD_OFS_DIN_HI, 8'h5a);
	endtask
	task automatic t_conv();
		put(ACPD_OFS_TRIG, 8'h00);
		chk("trigger", {15'h0, trig}, 16'h1);
		repeat (10) @(negedge i_ref_clk);
		get(ACPD_OFS_CONV_HI, 8'h0a);
		get(ACPD_OFS_CONV_LO, 8'hbc);
		get(ACPD_OFS_CONV_HI, 8'h1a);
		put(ACPD_OFS_IRQ_CLR, 8'h5a);
		chk("irq clear", {15'h0, irq_clr}, 16'h1);
		put(ACPD_OFS_CONV_LO, 8'h34);
		chk("dac held", {4'h0, dac}, 16'h0);
		put(ACPD_OFS_CONV_HI, 8'hf2);
		chk("dac", {3'h0, dac_upd, dac}, 16'h1234);
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ==========
	// Sequence
	initial begin
		repeat (4) @(posedge i_ref_clk);
		@(negedge i_ref_clk);
		i_rst = 1'b0;
		chk("reset", {5'h0, chan, 5'h0, gain}, 16'h0);
		get(ACPD_OFS_CONV_HI, 8'h10);
		t_counters();
		t_latches();
		t_conv();
		close_out();
	end
	initial begin
		#100000;
		fails++;
		close_out();
	end
endmodule // acpd_port_decoder_tb
